// ==== hdl/twmc_pkg.sv ====
// twmc_pkg: constants shared by the waveform mode control block
// assumes a single 40 MHz clock domain, timer tick supplied as a qualifier
package twmc_pkg;
    localparam logic [7:0]  ADDR_CTRL_A    = 8'h80;
    localparam logic [7:0]  ADDR_CTRL_B    = 8'h81;
    localparam logic [7:0]  ADDR_CMP_A_LO  = 8'h88;
    localparam logic [7:0]  ADDR_CMP_A_HI  = 8'h89;
    localparam logic [7:0]  ADDR_CMP_B_LO  = 8'h8a;
    localparam logic [7:0]  ADDR_CMP_B_HI  = 8'h8b;
    localparam logic [7:0]  ADDR_CAPT_LO   = 8'h86;
    localparam logic [7:0]  ADDR_CAPT_HI   = 8'h87;
    localparam logic [7:0]  ADDR_CNT_LO    = 8'h84;
    localparam logic [7:0]  ADDR_CNT_HI    = 8'h85;
    localparam logic [7:0]  ADDR_FLAGS     = 8'h96;
    localparam logic [7:0]  ADDR_DIR       = 8'h97;
    localparam logic [7:0]  CTRL_A_RESET   = 8'h00;
    localparam logic [7:0]  CTRL_B_RESET   = 8'h00;
    localparam logic [7:0]  CTRL_A_WMASK   = 8'hf3;
    localparam logic [7:0]  CTRL_B_WMASK   = 8'h18;
    localparam int          CHA_HI         = 7;
    localparam int          CHA_LO         = 6;
    localparam int          CHB_HI         = 5;
    localparam int          CHB_LO         = 4;
    localparam int          MODE_HI_POS    = 3;
    localparam int          FLAG_OVF_POS   = 0;
    localparam int          FLAG_CMPA_POS  = 1;
    localparam int          FLAG_CMPB_POS  = 2;
    localparam logic [15:0] TOP_MAX        = 16'hffff;
    localparam logic [15:0] TOP_8BIT       = 16'h00ff;
    localparam logic [15:0] TOP_9BIT       = 16'h01ff;
    localparam logic [15:0] TOP_10BIT      = 16'h03ff;
    localparam logic [15:0] BOTTOM         = 16'h0000;
    localparam logic [3:0]  MODE_NORMAL    = 4'h0;
    localparam logic [3:0]  MODE_CTC_CMPA  = 4'h4;
    localparam logic [3:0]  MODE_PFC_CMPA  = 4'h9;
    localparam logic [3:0]  MODE_PC_CMPA   = 4'hb;
    localparam logic [3:0]  MODE_CTC_CAPT  = 4'hc;
    localparam logic [3:0]  MODE_FAST_CAPT = 4'he;
    localparam logic [3:0]  MODE_FAST_CMPA = 4'hf;
    typedef enum logic [1:0] {
        TWMC_CLS_NONPWM = 2'h0,
        TWMC_CLS_FAST   = 2'h1,
        TWMC_CLS_DUAL   = 2'h3
    } twmc_class_t;
    typedef enum logic [1:0] {
        TWMC_UPD_NOW    = 2'h0,
        TWMC_UPD_TOP    = 2'h1,
        TWMC_UPD_BOTTOM = 2'h3
    } twmc_upd_t;
    typedef enum logic [1:0] {
        TWMC_OVF_MAX    = 2'h0,
        TWMC_OVF_TOP    = 2'h1,
        TWMC_OVF_BOTTOM = 2'h3
    } twmc_ovf_t;
endpackage

// ==== hdl/twmc_wave_out.sv ====
// twmc_wave_out: one waveform output channel and its pin override
// assumes match/bottom/direction qualifiers are computed by the caller
`timescale 1ns/1ps
module twmc_wave_out #(
    parameter bit IS_CHAN_A = 1'b1
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                timerTick,
    input  wire logic [1:0]          outputAction,
    input  wire twmc_pkg::twmc_class_t modeClass,
    input  wire logic                toggleAllowed,
    input  wire logic                matchHit,
    input  wire logic                matchIsTop,
    input  wire logic                atBottom,
    input  wire logic                countingDown,
    input  wire logic                dirBit,
    output logic                     waveOut,
    output logic                     pinDrive,
    output logic                     pinEnable
);
    logic waveReg;
    logic waveNext;

    always_comb begin
        waveNext = waveReg;
        unique case (modeClass)
            twmc_pkg::TWMC_CLS_NONPWM: begin
                if (matchHit) begin // R7
                    unique case (outputAction)
                        2'h1: waveNext = ~waveReg;
                        2'h2: waveNext = 1'b0;
                        2'h3: waveNext = 1'b1;
                        default: waveNext = waveReg;
                    endcase
                end
            end
            twmc_pkg::TWMC_CLS_FAST: begin
                if (outputAction == 2'h1) begin // R8
                    if (matchHit && IS_CHAN_A && toggleAllowed) waveNext = ~waveReg;
                end else if (outputAction[1]) begin
                    // a match at TOP is dropped; bottom still sets or clears
                    if (matchHit && !matchIsTop) waveNext = outputAction[0]; // R9 R10
                    else if (atBottom) waveNext = ~outputAction[0]; // R9 R10
                end
            end
            default: begin
                if (outputAction == 2'h1) begin // R11
                    if (matchHit && IS_CHAN_A && toggleAllowed) waveNext = ~waveReg;
                end else if (outputAction[1] && matchHit) begin
                    waveNext = outputAction[0] ^ countingDown; // R12
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            waveReg <= 1'b0;
        end else if (timerTick) begin // R1 R21
            waveReg <= waveNext;
        end
    end

    // override when connected; pin driver only when direction set
    logic connected;
    always_comb begin
        connected = |outputAction; // R4
        if (modeClass != twmc_pkg::TWMC_CLS_NONPWM && outputAction == 2'h1)
            connected = IS_CHAN_A && toggleAllowed;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pinEnable <= 1'b0;
            pinDrive  <= 1'b0;
            waveOut   <= 1'b0;
        end else begin
            pinEnable <= connected && dirBit; // R4 R5
            // follow the registered wave so the pin moves on an unticked edge only when the connection changes
            pinDrive  <= connected && (timerTick ? waveNext : waveReg); // R21
            waveOut   <= (timerTick) ? waveNext : waveReg;
        end
    end
endmodule // twmc_wave_out

// ==== hdl/twmc_timer.sv ====
// How it works
// [R1] one clock; tick only qualifies updates
// [R2] dual-slope freq-correct reloads compares at BOTTOM
// [R3] compare buffers load only at update point
// [R4] nonzero action field overrides pin function; in PWM modes code 01 connects only channel A, and only in modes 9/11/14/15
// [R5] pin driven only when direction bit set
// [R6] action meaning follows waveform mode class
// [R7] non-PWM: off, toggle, clear, set
// [R8] fast code 01 toggles A in 14/15
// [R9] fast 10 non-inverting, 11 inverting
// [R10] fast: match at TOP ignored, bottom kept
// [R11] dual code 01 toggles A in 9/11
// [R12] dual: 10 clear up, set down
// [R13] mode from control A low, control B high
// [R14] modes 0,4,12 immediate update, overflow MAX
// [R15] phase-correct: update TOP, overflow BOTTOM
// [R16] fast: update BOTTOM, overflow TOP
// [R17] modes 8,9 update and overflow BOTTOM
// [R18] software never selects mode 13
// [R19] dual-slope holds TOP one tick
// [R20] freq-correct overflow with BOTTOM reload
// [R21] outputs change only on ticked edges; pinEnable and the pin connection follow register writes on any edge
// [R22] control resets to normal, outputs off
// twmc_timer: 16-bit counter with mode decode and two waveform channels
// assumes a byte register port with read data one cycle after the strobe
`timescale 1ns/1ps
module twmc_timer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       timerTick,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    output logic            waveOutA,
    output logic            waveOutB,
    output logic            pinDriveA,
    output logic            pinEnableA,
    output logic            pinDriveB,
    output logic            pinEnableB
);
    logic [7:0]  waveform_control_a_reg;
    logic [7:0]  waveform_control_b_reg;
    logic [15:0] compare_value_a_reg;
    logic [15:0] compare_value_b_reg;
    logic [15:0] bufA_reg;
    logic [15:0] bufB_reg;
    logic [15:0] capture_register_reg;
    logic [15:0] counter_value_reg;
    logic [2:0]  flags_reg;
    logic [1:0]  dir_reg;
    logic        countDown_reg;
    logic [7:0]  hiTemp_reg;

    logic [3:0]           waveform_mode;
    twmc_pkg::twmc_class_t modeClass;
    twmc_pkg::twmc_upd_t   updPoint;
    twmc_pkg::twmc_ovf_t   ovfPoint;
    logic [15:0]          topValue;
    logic                 clearOnTop;
    logic                 atTop;
    logic                 atBottom;
    logic                 matchA;
    logic                 matchB;
    logic                 loadPoint;
    logic                 ovfEvent;
    logic                 toggleOk;
    logic                 wrHit;

    assign waveform_mode = {waveform_control_b_reg[4:3], waveform_control_a_reg[1:0]}; // R13

    always_comb begin
        modeClass  = twmc_pkg::TWMC_CLS_DUAL;
        updPoint   = twmc_pkg::TWMC_UPD_TOP;
        ovfPoint   = twmc_pkg::TWMC_OVF_BOTTOM;
        topValue   = twmc_pkg::TOP_MAX;
        clearOnTop = 1'b0;
        toggleOk   = 1'b0;
        unique case (waveform_mode) // R6
            4'h0: begin
                modeClass = twmc_pkg::TWMC_CLS_NONPWM; // R14
                updPoint  = twmc_pkg::TWMC_UPD_NOW;
                ovfPoint  = twmc_pkg::TWMC_OVF_MAX;
            end
            4'h1: topValue = twmc_pkg::TOP_8BIT; // R15
            4'h2: topValue = twmc_pkg::TOP_9BIT;
            4'h3: topValue = twmc_pkg::TOP_10BIT;
            4'h4, 4'hc: begin
                modeClass  = twmc_pkg::TWMC_CLS_NONPWM; // R14
                updPoint   = twmc_pkg::TWMC_UPD_NOW;
                ovfPoint   = twmc_pkg::TWMC_OVF_MAX;
                clearOnTop = 1'b1;
                topValue   = (waveform_mode == twmc_pkg::MODE_CTC_CMPA) ? compare_value_a_reg : capture_register_reg;
            end
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
                modeClass  = twmc_pkg::TWMC_CLS_FAST; // R16
                updPoint   = twmc_pkg::TWMC_UPD_BOTTOM;
                ovfPoint   = twmc_pkg::TWMC_OVF_TOP;
                clearOnTop = 1'b1;
                toggleOk   = waveform_mode[3]; // R8
                unique case (waveform_mode)
                    4'h5: topValue = twmc_pkg::TOP_8BIT;
                    4'h6: topValue = twmc_pkg::TOP_9BIT;
                    4'h7: topValue = twmc_pkg::TOP_10BIT;
                    4'he: topValue = capture_register_reg;
                    default: topValue = compare_value_a_reg;
                endcase
            end
            4'h8, 4'h9: begin
                updPoint = twmc_pkg::TWMC_UPD_BOTTOM; // R17 R2
                topValue = waveform_mode[0] ? compare_value_a_reg : capture_register_reg;
                toggleOk = waveform_mode[0]; // R11
            end
            4'ha, 4'hb: begin
                topValue = waveform_mode[0] ? compare_value_a_reg : capture_register_reg; // R15
                toggleOk = waveform_mode[0]; // R11
            end
            default: begin
                // reserved code: counter behaves as normal mode
                modeClass = twmc_pkg::TWMC_CLS_NONPWM; // R18
                updPoint  = twmc_pkg::TWMC_UPD_NOW;
                ovfPoint  = twmc_pkg::TWMC_OVF_MAX;
            end
        endcase
    end

    assign atTop    = (counter_value_reg == topValue);
    assign atBottom = (counter_value_reg == twmc_pkg::BOTTOM);
    assign matchA   = (counter_value_reg == compare_value_a_reg);
    assign matchB   = (counter_value_reg == compare_value_b_reg);

    always_comb begin
        unique case (updPoint) // R3
            twmc_pkg::TWMC_UPD_TOP:    loadPoint = atTop;
            twmc_pkg::TWMC_UPD_BOTTOM: loadPoint = atBottom; // R2
            default:                   loadPoint = 1'b1;
        endcase
        unique case (ovfPoint)
            twmc_pkg::TWMC_OVF_TOP:    ovfEvent = atTop;
            twmc_pkg::TWMC_OVF_BOTTOM: ovfEvent = atBottom && countDown_reg; // R20
            default:                   ovfEvent = (counter_value_reg == twmc_pkg::TOP_MAX);
        endcase
    end

    // counter: dual-slope reverses after one tick at TOP
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_value_reg <= twmc_pkg::BOTTOM;
            countDown_reg     <= 1'b0;
        end else if (wrHit && regAddr == twmc_pkg::ADDR_CNT_LO) begin
            counter_value_reg <= {hiTemp_reg, regWrData};
        end else if (timerTick) begin // R1
            if (modeClass == twmc_pkg::TWMC_CLS_DUAL) begin
                if (atTop) begin
                    countDown_reg     <= 1'b1; // R19
                    counter_value_reg <= counter_value_reg - 16'h0001;
                end else if (atBottom) begin
                    countDown_reg     <= 1'b0;
                    counter_value_reg <= counter_value_reg + 16'h0001;
                end else if (countDown_reg) begin
                    counter_value_reg <= counter_value_reg - 16'h0001;
                end else begin
                    counter_value_reg <= counter_value_reg + 16'h0001;
                end
            end else begin
                countDown_reg     <= 1'b0;
                counter_value_reg <= (clearOnTop && atTop) ? twmc_pkg::BOTTOM : counter_value_reg + 16'h0001;
            end
        end
    end

    assign wrHit = regWrEn;

    // control and direction registers
    always_ff @(posedge clk) begin
        if (rst) begin
            waveform_control_a_reg <= twmc_pkg::CTRL_A_RESET; // R22
            waveform_control_b_reg <= twmc_pkg::CTRL_B_RESET;
            dir_reg                <= 2'h0;
            hiTemp_reg             <= 8'h00;
        end else if (wrHit) begin
            if (regAddr == twmc_pkg::ADDR_CTRL_A) waveform_control_a_reg <= regWrData & twmc_pkg::CTRL_A_WMASK;
            if (regAddr == twmc_pkg::ADDR_CTRL_B) waveform_control_b_reg <= regWrData & twmc_pkg::CTRL_B_WMASK;
            if (regAddr == twmc_pkg::ADDR_DIR) dir_reg <= regWrData[1:0];
            if (regAddr[0]) hiTemp_reg <= regWrData;
        end
    end

    // compare buffers and active values
    always_ff @(posedge clk) begin
        if (rst) begin
            bufA_reg             <= 16'h0000;
            bufB_reg             <= 16'h0000;
            compare_value_a_reg  <= 16'h0000;
            compare_value_b_reg  <= 16'h0000;
            capture_register_reg <= 16'h0000;
        end else begin
            if (wrHit && regAddr == twmc_pkg::ADDR_CMP_A_LO) bufA_reg <= {hiTemp_reg, regWrData};
            if (wrHit && regAddr == twmc_pkg::ADDR_CMP_B_LO) bufB_reg <= {hiTemp_reg, regWrData};
            if (wrHit && regAddr == twmc_pkg::ADDR_CAPT_LO) capture_register_reg <= {hiTemp_reg, regWrData};
            if (updPoint == twmc_pkg::TWMC_UPD_NOW) begin
                compare_value_a_reg <= bufA_reg; // R3 R14
                compare_value_b_reg <= bufB_reg;
            end else if (timerTick && loadPoint) begin // R3 R2
                compare_value_a_reg <= bufA_reg;
                compare_value_b_reg <= bufB_reg;
            end
        end
    end

    // flags: hardware set wins over a software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= 3'h0;
        end else begin
            flags_reg[twmc_pkg::FLAG_OVF_POS] <= (timerTick && ovfEvent) ||
                (flags_reg[twmc_pkg::FLAG_OVF_POS] && !(wrHit && regAddr == twmc_pkg::ADDR_FLAGS && regWrData[0])); // R20
            flags_reg[twmc_pkg::FLAG_CMPA_POS] <= (timerTick && matchA) ||
                (flags_reg[twmc_pkg::FLAG_CMPA_POS] && !(wrHit && regAddr == twmc_pkg::ADDR_FLAGS && regWrData[1]));
            flags_reg[twmc_pkg::FLAG_CMPB_POS] <= (timerTick && matchB) ||
                (flags_reg[twmc_pkg::FLAG_CMPB_POS] && !(wrHit && regAddr == twmc_pkg::ADDR_FLAGS && regWrData[2]));
        end
    end

    // read port: data valid the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            unique case (regAddr)
                twmc_pkg::ADDR_CTRL_A:   regRdData <= waveform_control_a_reg;
                twmc_pkg::ADDR_CTRL_B:   regRdData <= waveform_control_b_reg;
                twmc_pkg::ADDR_CNT_LO:   regRdData <= counter_value_reg[7:0];
                twmc_pkg::ADDR_CNT_HI:   regRdData <= counter_value_reg[15:8];
                twmc_pkg::ADDR_CMP_A_LO: regRdData <= compare_value_a_reg[7:0];
                twmc_pkg::ADDR_CMP_A_HI: regRdData <= compare_value_a_reg[15:8];
                twmc_pkg::ADDR_CMP_B_LO: regRdData <= compare_value_b_reg[7:0];
                twmc_pkg::ADDR_CMP_B_HI: regRdData <= compare_value_b_reg[15:8];
                twmc_pkg::ADDR_CAPT_LO:  regRdData <= capture_register_reg[7:0];
                twmc_pkg::ADDR_CAPT_HI:  regRdData <= capture_register_reg[15:8];
                twmc_pkg::ADDR_FLAGS:    regRdData <= {5'h00, flags_reg};
                twmc_pkg::ADDR_DIR:      regRdData <= {6'h00, dir_reg};
                default:                 regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    twmc_wave_out #(.IS_CHAN_A(1'b1)) u_chan_a (
        .clk          (clk),
        .rst          (rst),
        .timerTick    (timerTick),
        .outputAction (waveform_control_a_reg[7:6]),
        .modeClass    (modeClass),
        .toggleAllowed(toggleOk),
        .matchHit     (matchA),
        .matchIsTop   (compare_value_a_reg == topValue),
        .atBottom     (atBottom),
        .countingDown (countDown_reg || (modeClass == twmc_pkg::TWMC_CLS_DUAL && atTop)),
        .dirBit       (dir_reg[0]),
        .waveOut      (waveOutA),
        .pinDrive     (pinDriveA),
        .pinEnable    (pinEnableA)
    );

    twmc_wave_out #(.IS_CHAN_A(1'b0)) u_chan_b (
        .clk          (clk),
        .rst          (rst),
        .timerTick    (timerTick),
        .outputAction (waveform_control_a_reg[5:4]),
        .modeClass    (modeClass),
        .toggleAllowed(toggleOk),
        .matchHit     (matchB),
        .matchIsTop   (compare_value_b_reg == topValue),
        .atBottom     (atBottom),
        .countingDown (countDown_reg || (modeClass == twmc_pkg::TWMC_CLS_DUAL && atTop)),
        .dirBit       (dir_reg[1]),
        .waveOut      (waveOutB),
        .pinDrive     (pinDriveB),
        .pinEnable    (pinEnableB)
    );

    sequence s_top_tick;
        timerTick && atTop && modeClass == twmc_pkg::TWMC_CLS_DUAL && !wrHit;
    endsequence

    property p_reverse_at_top;
        @(posedge clk) disable iff (rst) s_top_tick |=> countDown_reg;
    endproperty
    a_reverse_at_top: assert property (p_reverse_at_top) else $error("no reversal after TOP"); // R19

    property p_pin_needs_dir;
        @(posedge clk) disable iff (rst) pinEnableA |-> $past(dir_reg[0]);
    endproperty
    a_pin_needs_dir: assert property (p_pin_needs_dir) else $error("pin A driven without direction"); // R5

    property p_pin_b_needs_dir;
        @(posedge clk) disable iff (rst) pinEnableB |-> $past(dir_reg[1]);
    endproperty
    a_pin_b_needs_dir: assert property (p_pin_b_needs_dir) else $error("pin B driven without direction"); // R5

    property p_bottom_reload;
        @(posedge clk) disable iff (rst)
            (timerTick && updPoint == twmc_pkg::TWMC_UPD_BOTTOM && !atBottom) |=> $stable(compare_value_a_reg);
    endproperty
    a_bottom_reload: assert property (p_bottom_reload) else $error("compare A changed off BOTTOM"); // R2

    property p_hold_off_tick;
        @(posedge clk) disable iff (rst) !timerTick |=> $stable(counter_value_reg) || $past(wrHit);
    endproperty
    a_hold_off_tick: assert property (p_hold_off_tick) else $error("counter moved without tick"); // R1

    property p_ovf_set;
        @(posedge clk) disable iff (rst) (timerTick && ovfEvent) |=> flags_reg[twmc_pkg::FLAG_OVF_POS];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set"); // R20

    property p_mode_decode;
        @(posedge clk) disable iff (rst)
            (waveform_mode == twmc_pkg::MODE_NORMAL && timerTick && atTop && !wrHit)
            |=> atBottom && flags_reg[twmc_pkg::FLAG_OVF_POS];
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("normal mode did not wrap at MAX"); // R14

    sequence s_fast_top;
        timerTick && atTop && modeClass == twmc_pkg::TWMC_CLS_FAST && !wrHit;
    endsequence

    property p_fast_wrap;
        @(posedge clk) disable iff (rst) s_fast_top |=> atBottom && flags_reg[twmc_pkg::FLAG_OVF_POS];
    endproperty
    a_fast_wrap: assert property (p_fast_wrap) else $error("fast mode did not wrap at TOP"); // R16

    property p_pfc_ovf_reload;
        @(posedge clk) disable iff (rst)
            (timerTick && atBottom && countDown_reg && waveform_mode[3:1] == 3'h4)
            |=> flags_reg[twmc_pkg::FLAG_OVF_POS] && compare_value_a_reg == $past(bufA_reg);
    endproperty
    a_pfc_ovf_reload: assert property (p_pfc_ovf_reload) else $error("overflow and reload apart"); // R2 R20

    property p_reset_ctrl;
        @(posedge clk) $past(rst) |-> waveform_control_a_reg == twmc_pkg::CTRL_A_RESET && !pinEnableA && !pinEnableB;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not cleared by reset"); // R22

    property p_wave_on_tick;
        @(posedge clk) disable iff (rst) !$past(timerTick) && !timerTick |-> $stable(waveOutA);
    endproperty
    a_wave_on_tick: assert property (p_wave_on_tick) else $error("wave A moved without tick"); // R21
endmodule // twmc_timer

// ==== dv/tb_twmc_timer.sv ====
// tb_twmc_timer: self-checking bench for the waveform mode control timer
// assumes a 40 MHz clock, byte register port, timer tick held high unless a test stalls it
`timescale 1ns/1ps
module tb_twmc_timer;
    logic       clk, rst, timerTick, regWrEn, regRdEn;
    logic [7:0] regAddr, regWrData, regRdData;
    logic       waveOutA, waveOutB, pinDriveA, pinEnableA, pinDriveB, pinEnableB;
    int         miscompares, checkCount;

    twmc_timer twmc_timer_inst (.clk(clk), .rst(rst), .timerTick(timerTick), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .waveOutA(waveOutA), .waveOutB(waveOutB), .pinDriveA(pinDriveA), .pinEnableA(pinEnableA),
        .pinDriveB(pinDriveB), .pinEnableB(pinEnableB));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
        @(posedge clk); regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk); regAddr <= a; regRdEn <= 1'b1;
        @(posedge clk); regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask

    // fresh reset per setup so every scenario starts from a known count
    task automatic cfg(input logic [3:0] mode, input logic [1:0] aa, input logic [1:0] ab,
                       input logic [1:0] dir, input logic [15:0] cmp);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr(twmc_pkg::ADDR_DIR, {6'h00, dir});
        wr(twmc_pkg::ADDR_CMP_A_HI, cmp[15:8]);
        wr(twmc_pkg::ADDR_CMP_A_LO, cmp[7:0]);
        wr(twmc_pkg::ADDR_CMP_B_HI, cmp[15:8]);
        wr(twmc_pkg::ADDR_CMP_B_LO, cmp[7:0]);
        wr(twmc_pkg::ADDR_CTRL_B, {3'h0, mode[3:2], 3'h0});
        wr(twmc_pkg::ADDR_CTRL_A, {aa, ab, 2'h0, mode[1:0]});
    endtask

    // whole periods are measured, so the phase at the start does not matter
    task automatic measure(input logic [3:0] mode, input logic [1:0] act, input logic [15:0] cmp,
                           input int n, output int h);
        int dis;
        cfg(mode, act, act, 2'b11, cmp);
        repeat (600) @(posedge clk);
        h = 0;
        dis = 0;
        repeat (n) begin
            @(posedge clk);
            #1 if (waveOutA === 1'b1) h++;
            if ({waveOutB, pinDriveA, pinDriveB} !== {3{waveOutA}}) dis++;
        end
        chk("channel b and pins against a", 16'h0000, dis[15:0]);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        rd(twmc_pkg::ADDR_CTRL_A, d); chk("ctrl a reset", 16'h0000, {8'h00, d});
        rd(twmc_pkg::ADDR_CTRL_B, d); chk("ctrl b reset", 16'h0000, {8'h00, d});
        chk("pin enables after reset", 16'h0000, {14'h0000, pinEnableA, pinEnableB});
        wr(twmc_pkg::ADDR_CTRL_A, 8'hff);
        wr(twmc_pkg::ADDR_CTRL_B, 8'hff);
        rd(twmc_pkg::ADDR_CTRL_A, d); chk("ctrl a writable", 16'h00f3, {8'h00, d});
        rd(twmc_pkg::ADDR_CTRL_B, d); chk("ctrl b writable", 16'h0018, {8'h00, d});
        wr(8'h00, 8'h5a);
        rd(8'h00, d); chk("unmapped read", 16'h0000, {8'h00, d});
    endtask

    // mode, action a, action b, direction, expected enables a/b
    task automatic t_conn();
        logic [11:0] tb [17] = '{12'h00c, 12'h07f, 12'h55c, 12'hf5e, 12'h15c,
                                 12'hb5e, 12'h95e, 12'hebf, 12'h080, 12'h086,
                                 12'hc7f, 12'h85c, 12'ha5c, 12'h25c, 12'h35c,
                                 12'h65c, 12'h75c};
        foreach (tb[i]) begin
            cfg(tb[i][11:8], tb[i][7:6], tb[i][5:4], tb[i][3:2], 16'h0040);
            repeat (3) @(posedge clk);
            #1 chk("pin enables", {14'h0000, tb[i][1:0]}, {14'h0000, pinEnableA, pinEnableB});
        end
    endtask

    task automatic t_tick();
        logic w;
        int   k;
        timerTick <= 1'b0;
        cfg(4'h4, 2'b01, 2'b00, 2'b01, 16'h0003);
        #1 w = waveOutA;
        repeat (20) @(posedge clk);
        #1 chk("output without tick", {15'h0000, w}, {15'h0000, waveOutA});
        timerTick <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            w = waveOutA;
            k = 0;
            while (waveOutA === w && k < 50) begin
                @(posedge clk);
                #1 k++;
            end
        end
        chk("toggle interval", 16'h0004, k[15:0]);
    endtask

    task automatic t_ovf();
        logic [7:0] d;
        cfg(4'h0, 2'b00, 2'b00, 2'b00, 16'h0000);
        wr(twmc_pkg::ADDR_FLAGS, 8'h01);
        rd(twmc_pkg::ADDR_FLAGS, d); chk("overflow before max", 16'h0000, {15'h0000, d[0]});
        wr(twmc_pkg::ADDR_CNT_HI, 8'hff);
        wr(twmc_pkg::ADDR_CNT_LO, 8'hfd);
        repeat (8) @(posedge clk);
        rd(twmc_pkg::ADDR_FLAGS, d); chk("overflow at max", 16'h0001, {15'h0000, d[0]});
    endtask

    task automatic t_pwm();
        int a, b, c;
        measure(4'h5, 2'b10, 16'h0040, 256, a);
        measure(4'h5, 2'b10, 16'h0020, 256, b);
        chk("fast duty step", 16'd32, 16'(a - b));
        measure(4'h5, 2'b11, 16'h0040, 256, c);
        chk("fast inverted sum", 16'd256, 16'(a + c));
        measure(4'h5, 2'b10, 16'h00ff, 256, a); chk("fast cmp top", 16'd256, 16'(a));
        measure(4'h5, 2'b11, 16'h00ff, 256, a); chk("fast inv cmp top", 16'd0, 16'(a));
        measure(4'h1, 2'b10, 16'h0040, 510, a); chk("dual high", 16'd128, 16'(a));
        measure(4'h1, 2'b11, 16'h0040, 510, a); chk("dual inv high", 16'd382, 16'(a));
        measure(4'h9, 2'b10, 16'h0040, 128, a); chk("dual cmp at top", 16'd128, 16'(a));
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        rst = 1'b1; timerTick = 1'b1; regWrEn = 1'b0; regRdEn = 1'b0;
        regAddr = 8'h00; regWrData = 8'h00;
        miscompares = 0; checkCount = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_conn();
        t_tick();
        t_ovf();
        t_pwm();
        end_of_test();
    end
endmodule // tb_twmc_timer
